// *** stpg_params.svh ***
// Offsets, field positions, rate limits, error codes and timing figures of the step pulse generator
`ifndef STPG_PARAMS_SVH
`define STPG_PARAMS_SVH

`define STPG_CLK_PERIOD_NS  32'h0000_0008
`define STPG_CLK_HZ         (32'h3b9a_ca00 / `STPG_CLK_PERIOD_NS)

`define STPG_RATE_MIN       12'h032
`define STPG_RATE_MAX       12'h7d0
`define STPG_RATE_STEP      12'h032
`define STPG_NUM_PATTERNS   6'h28
`define STPG_CONTACT_BITS   16

`define STPG_OFS_CTRL       8'h00
`define STPG_OFS_STATUS     8'h04
`define STPG_OFS_PATSEL     8'h08
`define STPG_OFS_PATCNT     8'h0c
`define STPG_OFS_PATCFG     8'h10
`define STPG_OFS_PATBITS    8'h14
`define STPG_OFS_CONTACT    8'h18
`define STPG_OFS_EMITTED    8'h1c

`define STPG_CTRL_START     8
`define STPG_CFG_RAMP       12
`define STPG_CFG_SLOPE_LSB  16
`define STPG_BITS_END_LSB   8
`define STPG_BITS_STOP_LSB  16
`define STPG_STAT_ERR_LSB   8

`define STPG_ERR_NONE       2'h0
`define STPG_ERR_BUSY       2'h1
`define STPG_ERR_RATE       2'h2
`define STPG_ERR_SLOPE      2'h3

`endif

// *** stpg_pkg.sv ***
// Types shared by the step pulse generator
package stpg_pkg;
	typedef enum logic [1:0] {RUN_IDLE, RUN_ACCEL, RUN_CRUISE, RUN_DECEL} stpg_state_t;
	typedef logic [1:0] stpg_err_t;
endpackage : stpg_pkg

// *** stpg_rate_div.sv ***
// Phase accumulator that toggles at twice the requested pulse rate
`timescale 1ns/1ps
`default_nettype none
`include "stpg_params.svh"
module stpg_rate_div #(
	parameter int unsigned CLK_HZ = `STPG_CLK_HZ,
	parameter int          RW     = 12
) (
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          nrst,
	// Rate request
	input  wire logic          en,
	input  wire logic [RW-1:0] rate,
	// Half-period enable
	output logic               tick
);
	localparam int AW = $clog2(CLK_HZ) + 1;
	logic [AW-1:0] accQ;
	logic [AW-1:0] accD;
	logic [AW-1:0] sumW;
	logic          hit;

	always_comb begin
		sumW = accQ + AW'({rate, 1'b0});
		hit  = (sumW >= AW'(CLK_HZ));
		accD = hit ? (sumW - AW'(CLK_HZ)) : sumW;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			accQ <= '0;
			tick <= 1'b0;
		end else if (!en) begin
			accQ <= '0;
			tick <= 1'b0;
		end else begin
			accQ <= accD;
			tick <= hit;
		end
	end
endmodule : stpg_rate_div
`default_nettype wire

// *** stpg_top.sv ***
// Step pulse and direction generator with stored motion patterns behind APB
// How it works
// - Pulse rate stays within 50 to 2000 pps
// - Drive step pulse and direction outputs
// - Trapezoid runs ramp up, cruise, ramp down
// - Constant mode emits all pulses at cruise rate
// - Endless mode runs flat until emergency stop
// - Forty numbered patterns, start runs chosen one
// - Cruise rate 50 to 2000 in steps of 50
// - Ramp enable picks trapezoid except in endless mode, else constant rate
// - Integer slope sets ramp steepness when enabled
// - Ramp down reuses the ramp up slope
// - Ramp pulses: level times slope times two summed
// - Ramp time follows levels, slope and forty ms
// - Pattern names direction, endless, stop contact bits
// - Busy flag high while a run lasts
// - Bad rate gives error 02, no run
// - Twice the ramp pulses above total give error 03
// - Start while busy gives error 01
`timescale 1ns/1ps
`default_nettype none
`include "stpg_params.svh"
module stpg_top
	import stpg_pkg::*;
#(
	parameter int unsigned CLK_HZ = `STPG_CLK_HZ,
	parameter int          NPAT   = 40
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Motor driver side
	output logic             stepPulsePin,
	output logic             directionPin,
	output logic             pulseActiveFlag
);
	// Pattern storage
	logic [31:0] cntMem   [NPAT];
	logic [11:0] rateMem  [NPAT];
	logic        rampMem  [NPAT];
	logic [7:0]  slopeMem [NPAT];
	logic [3:0]  dirMem   [NPAT];
	logic [3:0]  endMem   [NPAT];
	logic [3:0]  stopMem  [NPAT];

	logic [5:0]  patSelQ;
	logic [15:0] contactQ;
	logic [5:0]  lastPatQ;

	// Run state
	stpg_state_t stateQ;
	logic        busyQ;
	logic        stepQ;
	logic        dirQ;
	logic        endlessQ;
	logic        rampQ;
	logic [31:0] remQ;
	logic [31:0] emittedQ;
	logic [19:0] rampPulsesQ;
	logic [5:0]  lvlQ;
	logic [5:0]  topLvlQ;
	logic [15:0] lvlLeftQ;
	logic [7:0]  slopeQ;
	logic [11:0] cruiseQ;
	logic [3:0]  dirIdxQ;
	logic [3:0]  stopIdxQ;
	stpg_err_t   errQ;

	// APB decode
	logic        setupPh;
	logic        wrEn;
	logic        regHit;
	logic [31:0] rdMux;

	assign setupPh = psel & ~penable;
	assign wrEn    = psel & penable & pwrite & pready;

	always_comb begin
		regHit = 1'b1;
		rdMux  = 32'h0000_0000;
		case (paddr)
			`STPG_OFS_CTRL:    rdMux = {26'h000_0000, lastPatQ};
			`STPG_OFS_STATUS:  rdMux = {22'h00_0000, errQ, 7'h00, busyQ};
			`STPG_OFS_PATSEL:  rdMux = {26'h000_0000, patSelQ};
			`STPG_OFS_PATCNT:  rdMux = (patSelQ < NPAT) ? cntMem[patSelQ] : 32'h0000_0000;
			`STPG_OFS_PATCFG:  rdMux = (patSelQ < NPAT) ?
				{8'h00, slopeMem[patSelQ], 3'h0, rampMem[patSelQ], rateMem[patSelQ]} :
				32'h0000_0000;
			`STPG_OFS_PATBITS: rdMux = (patSelQ < NPAT) ?
				{12'h000, stopMem[patSelQ], 4'h0, endMem[patSelQ], 4'h0, dirMem[patSelQ]} :
				32'h0000_0000;
			`STPG_OFS_CONTACT: rdMux = {16'h0000, contactQ};
			`STPG_OFS_EMITTED: rdMux = emittedQ;
			default:           regHit = 1'b0;
		endcase
	end

	// Zero wait state answer, registered in the setup cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setupPh;
			prdata  <= (setupPh & ~pwrite) ? rdMux : 32'h0000_0000;
			pslverr <= setupPh & ~regHit;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			patSelQ  <= 6'h00;
			contactQ <= 16'h0000;
		end else if (wrEn) begin
			if (paddr == `STPG_OFS_PATSEL)
				patSelQ <= pwdata[5:0];
			if (paddr == `STPG_OFS_CONTACT)
				contactQ <= pwdata[15:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NPAT; gi++) begin : g_pat
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					cntMem[gi]   <= 32'h0000_0000;
					rateMem[gi]  <= `STPG_RATE_MIN;
					rampMem[gi]  <= 1'b0;
					slopeMem[gi] <= 8'h01;
					dirMem[gi]   <= 4'h0;
					endMem[gi]   <= 4'h1;
					stopMem[gi]  <= 4'h2;
				end else if (wrEn && patSelQ == 6'(gi)) begin
					if (paddr == `STPG_OFS_PATCNT)
						cntMem[gi] <= pwdata;
					if (paddr == `STPG_OFS_PATCFG) begin
						rateMem[gi]  <= pwdata[11:0];
						rampMem[gi]  <= pwdata[`STPG_CFG_RAMP];
						slopeMem[gi] <= pwdata[`STPG_CFG_SLOPE_LSB +: 8];
					end
					if (paddr == `STPG_OFS_PATBITS) begin
						dirMem[gi]  <= pwdata[3:0];
						endMem[gi]  <= pwdata[`STPG_BITS_END_LSB +: 4];
						stopMem[gi] <= pwdata[`STPG_BITS_STOP_LSB +: 4];
					end
				end
			end
		end
	endgenerate

	// Start request and pattern checks
	logic        startReq;
	logic [5:0]  sPat;
	logic        sValid;
	logic [11:0] sRate;
	logic [5:0]  sLvl;
	logic [19:0] sRamp;
	logic        sRampEn;
	logic        sEndless;
	logic        rateBad;
	logic        slopeBad;

	assign startReq = wrEn & (paddr == `STPG_OFS_CTRL) & pwdata[`STPG_CTRL_START];
	assign sPat     = pwdata[5:0];
	assign sValid   = (sPat < NPAT);

	always_comb begin
		sRate    = sValid ? rateMem[sPat] : 12'h000;
		sLvl     = 6'(sRate / `STPG_RATE_STEP);
		sEndless = sValid ? contactQ[endMem[sPat]] : 1'b0;
		// ramp only when enabled and not endless
		sRampEn  = sValid & rampMem[sPat] & ~sEndless & (slopeMem[sPat] != 8'h00) & (sLvl > 6'h01);
		// slope times level sum times two
		sRamp    = sRampEn ? 20'(20'(slopeMem[sPat]) * 20'(sLvl) * 20'(sLvl - 6'h01)) : 20'h00000;
		rateBad  = ~sValid | (sRate == 12'h000) | (sRate > `STPG_RATE_MAX) |
			((sRate % `STPG_RATE_STEP) != 12'h000);
		slopeBad = ~sEndless & (32'({sRamp, 1'b0}) > cntMem[sPat]);
	end

	// Pulse timing
	logic        tick;
	logic        pulseDone;
	logic        stopHit;
	logic [11:0] curRate;

	// ramp levels advance in 50 pps steps
	assign curRate   = (stateQ == RUN_CRUISE) ? cruiseQ : 12'(lvlQ * `STPG_RATE_STEP);
	assign pulseDone = busyQ & tick & stepQ;
	assign stopHit   = busyQ & contactQ[stopIdxQ];

	stpg_rate_div #(
		.CLK_HZ (CLK_HZ),
		.RW     (12)
	) u_div (
		.mclk (mclk),
		.nrst (nrst),
		.en   (busyQ & ~stopHit),
		.rate (curRate),
		.tick (tick)
	);

	function automatic logic [15:0] lvlPulses(input logic [5:0] lvl, input logic [7:0] slope);
		lvlPulses = {15'(16'(lvl) * 16'(slope)), 1'b0};
	endfunction : lvlPulses

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stateQ      <= RUN_IDLE;
			busyQ       <= 1'b0;
			stepQ       <= 1'b0;
			endlessQ    <= 1'b0;
			rampQ       <= 1'b0;
			remQ        <= 32'h0000_0000;
			rampPulsesQ <= 20'h00000;
			lvlQ        <= 6'h00;
			topLvlQ     <= 6'h00;
			lvlLeftQ    <= 16'h0000;
			slopeQ      <= 8'h00;
			cruiseQ     <= `STPG_RATE_MIN;
			dirIdxQ     <= 4'h0;
			stopIdxQ    <= 4'h0;
			errQ        <= `STPG_ERR_NONE;
			lastPatQ    <= 6'h00;
		end else if (startReq && busyQ) begin
			errQ <= `STPG_ERR_BUSY;
		end else if (startReq) begin
			lastPatQ <= sPat;
			if (rateBad) begin
				errQ <= `STPG_ERR_RATE;
			end else if (slopeBad) begin
				errQ <= `STPG_ERR_SLOPE;
			end else begin
				errQ        <= `STPG_ERR_NONE;
				endlessQ    <= sEndless;
				rampQ       <= sRampEn;
				remQ        <= cntMem[sPat];
				rampPulsesQ <= sRamp;
				slopeQ      <= slopeMem[sPat];
				cruiseQ     <= sRate;
				topLvlQ     <= sLvl;
				dirIdxQ     <= dirMem[sPat];
				stopIdxQ    <= stopMem[sPat];
				lvlQ        <= 6'h01;
				lvlLeftQ    <= lvlPulses(6'h01, slopeMem[sPat]);
				stateQ      <= sRampEn ? RUN_ACCEL : RUN_CRUISE;
				busyQ       <= sEndless | (cntMem[sPat] != 32'h0000_0000);
			end
		end else if (stopHit) begin
			stateQ <= RUN_IDLE;
			busyQ  <= 1'b0;
			stepQ  <= 1'b0;
		end else if (busyQ && tick) begin
			// step pulse toggles each half period
			stepQ <= ~stepQ;
			if (stepQ && !endlessQ) begin
				remQ <= remQ - 32'h0000_0001;
				if (remQ == 32'h0000_0001) begin
					// finite run ends on last pulse
					stateQ <= RUN_IDLE;
					busyQ  <= 1'b0;
				end else begin
					case (stateQ)
						RUN_ACCEL: begin
							lvlLeftQ <= lvlLeftQ - 16'h0001;
							if (lvlLeftQ == 16'h0001) begin
								if (lvlQ + 6'h01 == topLvlQ) begin
									stateQ   <= (remQ - 32'h0000_0001 == 32'(rampPulsesQ)) ?
										RUN_DECEL : RUN_CRUISE;
									lvlLeftQ <= lvlPulses(lvlQ, slopeQ);
								end else begin
									lvlQ     <= lvlQ + 6'h01;
									lvlLeftQ <= lvlPulses(lvlQ + 6'h01, slopeQ);
								end
							end
						end
						RUN_CRUISE: begin
							if (rampQ && remQ - 32'h0000_0001 == 32'(rampPulsesQ)) begin
								stateQ   <= RUN_DECEL;
								lvlQ     <= topLvlQ - 6'h01;
								lvlLeftQ <= lvlPulses(topLvlQ - 6'h01, slopeQ);
							end
						end
						RUN_DECEL: begin
							lvlLeftQ <= lvlLeftQ - 16'h0001;
							if (lvlLeftQ == 16'h0001 && lvlQ > 6'h01) begin
								lvlQ     <= lvlQ - 6'h01;
								lvlLeftQ <= lvlPulses(lvlQ - 6'h01, slopeQ);
							end
						end
						default: stateQ <= RUN_IDLE;
					endcase
				end
			end
		end
	end

	// Emitted pulse counter
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			emittedQ <= 32'h0000_0000;
		else if (startReq && !busyQ && !rateBad && !slopeBad)
			emittedQ <= 32'h0000_0000;
		else if (pulseDone && !stopHit)
			emittedQ <= emittedQ + 32'h0000_0001;
	end

	// direction follows the chosen contact bit
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			dirQ <= 1'b0;
		else if (busyQ)
			dirQ <= contactQ[dirIdxQ];
	end

	assign stepPulsePin    = stepQ;
	assign directionPin    = dirQ;
	assign pulseActiveFlag = busyQ;

	// Checks
	sequence startGood;
		startReq && !busyQ && !rateBad && !slopeBad;
	endsequence

	sequence startRateBad;
		startReq && !busyQ && rateBad;
	endsequence

	chk_rate_range: assert property (@(posedge mclk) disable iff (!nrst)
		busyQ |-> (curRate >= `STPG_RATE_MIN && curRate <= `STPG_RATE_MAX))
		else $error("pulse rate out of range");
	chk_dir_follow: assert property (@(posedge mclk) disable iff (!nrst)
		busyQ |=> directionPin == $past(contactQ[dirIdxQ]))
		else $error("direction output not following contact bit");
	chk_decel_final: assert property (@(posedge mclk) disable iff (!nrst)
		stateQ == RUN_DECEL |=> (stateQ == RUN_DECEL || stateQ == RUN_IDLE))
		else $error("ramp down left for another phase");
	chk_flat_mode: assert property (@(posedge mclk) disable iff (!nrst)
		(busyQ && !rampQ) |-> stateQ == RUN_CRUISE)
		else $error("constant mode left cruise");
	chk_endless_run: assert property (@(posedge mclk) disable iff (!nrst)
		(busyQ && endlessQ && !stopHit) |=> busyQ)
		else $error("endless run stopped without stop bit");
	chk_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		!busyQ |=> !stepPulsePin)
		else $error("step pulse while idle");
	chk_rate_error: assert property (@(posedge mclk) disable iff (!nrst)
		startRateBad |=> (errQ == `STPG_ERR_RATE && !busyQ))
		else $error("bad rate not refused");
	chk_ramp_error: assert property (@(posedge mclk) disable iff (!nrst)
		(startReq && !busyQ && !rateBad && slopeBad) |=> errQ == `STPG_ERR_SLOPE)
		else $error("oversized ramp not refused");
	chk_busy_error: assert property (@(posedge mclk) disable iff (!nrst)
		(startReq && busyQ) |=> (errQ == `STPG_ERR_BUSY && $stable(cruiseQ)))
		else $error("start while busy not refused");
	chk_count_end: assert property (@(posedge mclk) disable iff (!nrst)
		(pulseDone && !stopHit && !startReq && !endlessQ && remQ == 32'h0000_0001)
		|=> !busyQ ##1 !busyQ)
		else $error("run did not end on last pulse");
	chk_good_start: assert property (@(posedge mclk) disable iff (!nrst)
		startGood |=> (errQ == `STPG_ERR_NONE && lastPatQ == $past(sPat)))
		else $error("valid start not taken");
	chk_estop_halt: assert property (@(posedge mclk) disable iff (!nrst)
		(stopHit && !startReq) |=> (!busyQ && !stepPulsePin))
		else $error("emergency stop did not halt");
endmodule : stpg_top
`default_nettype wire

// *** stpg_drv_model.sv ***
// Motor driver model that counts and times step pulses
`timescale 1ns/1ps
`default_nettype none
module stpg_drv_model (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Driver inputs
	input  wire logic stepIn,
	// Observations
	output int        pulseCount,
	output int        lastGap,
	output logic      rise
);
	logic stepQ;
	int   gapCnt;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stepQ <= 1'b0;
			pulseCount <= 0;
			lastGap <= 0;
			gapCnt <= 0;
			rise <= 1'b0;
		end else begin
			stepQ <= stepIn;
			rise <= stepIn && !stepQ;
			gapCnt <= (stepIn && !stepQ) ? 1 : gapCnt + 1;
			if (stepIn && !stepQ) begin
				pulseCount <= pulseCount + 1;
				lastGap <= gapCnt;
			end
		end
	end
endmodule : stpg_drv_model
`default_nettype wire

// *** stpg_top_tb.sv ***
// Self-checking bench for the step pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "stpg_params.svh"
module stpg_top_tb;
	localparam int CLKHZ = 20000;
	logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, perr, rise;
	logic        stepPulsePin, directionPin, pulseActiveFlag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	int          n_errors, tests_run, cycles, pulseCount, lastGap, gi, c0, rc, rp, lo, hi;
	int          expGap[$];
	int          badRate[5] = '{0, 2050, 75, 2000, 50};

	stpg_top #(.CLK_HZ(CLKHZ), .NPAT(40)) i_stpg_top (.mclk(mclk), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stepPulsePin(stepPulsePin),
		.directionPin(directionPin), .pulseActiveFlag(pulseActiveFlag));
	stpg_drv_model i_stpg_drv_model (.mclk(mclk), .nrst(nrst), .stepIn(stepPulsePin),
		.pulseCount(pulseCount), .lastGap(lastGap), .rise(rise));

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	task automatic stop_test();
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : check

	always @(posedge mclk) begin
		if (rise === 1'b1 && gi < expGap.size()) begin
			if (gi > 0) begin
				lo = expGap[gi - 1] < expGap[gi] ? expGap[gi - 1] : expGap[gi];
				hi = expGap[gi - 1] < expGap[gi] ? expGap[gi] : expGap[gi - 1];
				tests_run++;
				if (lastGap < lo - 3 || lastGap > hi + 3) begin
					$display("ERROR gap %0d expected %0d..%0d seen %0d", gi, lo, hi, lastGap);
					n_errors++;
				end
			end
			gi++;
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, exp, rdat);
	endtask : rd

	function automatic int rampPulses(int rate, int slope);
		int s = 0;
		for (int k = 1; k < rate / 50; k++)
			s += 2 * k * slope;
		return s;
	endfunction : rampPulses

	function automatic int expErr(int pat, int cnt, int rate, bit ramp, int slope);
		if (pat >= 40 || rate == 0 || rate > 2000 || rate % 50 != 0)
			return 2;
		if (ramp && 2 * rampPulses(rate, slope) > cnt)
			return 3;
		return 0;
	endfunction : expErr

	task automatic plan(input int cnt, input int rate, input int slope, input bit ramp);
		int r;
		expGap.delete();
		gi = 0;
		r = ramp ? rampPulses(rate, slope) : 0;
		for (int k = 1; k < rate / 50; k++)
			repeat (ramp ? 2 * k * slope : 0) expGap.push_back(CLKHZ / (50 * k));
		repeat (cnt - 2 * r) expGap.push_back(CLKHZ / rate);
		for (int k = rate / 50 - 1; k > 0; k--)
			repeat (ramp ? 2 * k * slope : 0) expGap.push_back(CLKHZ / (50 * k));
	endtask : plan

	task automatic setPat(input int p, input int cnt, input int cfg, input int bits);
		apb(1'b1, `STPG_OFS_PATSEL, p);
		apb(1'b1, `STPG_OFS_PATCNT, cnt);
		apb(1'b1, `STPG_OFS_PATCFG, cfg);
		apb(1'b1, `STPG_OFS_PATBITS, bits);
	endtask : setPat

	// one pulse run at a time
	task automatic go(input int p);
		c0 = pulseCount;
		apb(1'b1, `STPG_OFS_CTRL, 32'h100 | p);
		@(posedge mclk);
		while (pulseActiveFlag !== 1'b0)
			@(posedge mclk);
	endtask : go

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(21));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		apb(1'b1, `STPG_OFS_PATSEL, 32'h27);
		rd(`STPG_OFS_PATCFG, 32'h0001_0032, "patcfg");
		rd(`STPG_OFS_PATBITS, 32'h0002_0100, "patbits");
		rd(`STPG_OFS_STATUS, 32'h0, "status");
		apb(1'b0, 8'h40, 32'h0);
		check("pslverr", 32'h1, {31'h0, perr});
		rp = $urandom_range(39);
		rc = $urandom_range(16, 1);
		apb(1'b1, `STPG_OFS_CONTACT, 32'h8);
		setPat(rp, rc, 32'h7d0, 32'h0002_0103);
		plan(rc, 2000, 0, 0);
		go(rp);
		check("pulses", rc, pulseCount - c0);
		check("dir", 32'h1, {31'h0, directionPin});
		check("step", 32'h0, {31'h0, stepPulsePin});
		rd(`STPG_OFS_EMITTED, rc, "emitted");
		rd(`STPG_OFS_CTRL, rp, "pattern");
		// second command runs the reverse direction
		setPat(1, 4, 32'h032, 32'h0002_0100);
		plan(4, 50, 0, 0);
		c0 = pulseCount;
		apb(1'b1, `STPG_OFS_CTRL, 32'h101);
		apb(1'b1, `STPG_OFS_CTRL, 32'h101);
		rd(`STPG_OFS_STATUS, 32'h101, "status busy");
		while (pulseActiveFlag !== 1'b0)
			@(posedge mclk);
		check("pulses", 32'h4, pulseCount - c0);
		check("reverse dir", 32'h0, {31'h0, directionPin});
		badRate[4] = $urandom_range(4095);
		foreach (badRate[i]) begin
			setPat(2, 0, badRate[i], 32'h0002_0100);
			go(2);
			rd(`STPG_OFS_STATUS, expErr(2, 0, badRate[i], 0, 1) << 8, "status rate");
		end
		go(40);
		rd(`STPG_OFS_STATUS, 32'h200, "status pattern");
		for (int s = 1; s <= 2; s++) begin
			rc = 2 * rampPulses(150, s) + 2;
			setPat(7, rc - 3, 32'h1096 | (s << 16), 32'h0002_0100);
			go(7);
			rd(`STPG_OFS_STATUS, expErr(7, rc - 3, 150, 1, s) << 8, "status ramp");
			apb(1'b1, `STPG_OFS_PATCNT, rc);
			plan(rc, 150, s, 1);
			go(7);
			check("ramp pulses", rc, pulseCount - c0);
		end
		apb(1'b1, `STPG_OFS_CONTACT, 32'h2);
		setPat(9, 3, 32'h7d0, 32'h0002_0103);
		plan(0, 2000, 0, 0);
		c0 = pulseCount;
		apb(1'b1, `STPG_OFS_CTRL, 32'h109);
		while (pulseCount - c0 < 10)
			@(posedge mclk);
		check("endless busy", 32'h1, {31'h0, pulseActiveFlag});
		check("endless dir", 32'h0, {31'h0, directionPin});
		apb(1'b1, `STPG_OFS_CONTACT, 32'h6);
		@(negedge mclk);
		check("stop busy", 32'h0, {31'h0, pulseActiveFlag});
		c0 = pulseCount;
		repeat (30) @(posedge mclk);
		check("stop pulses", c0, pulseCount);
		apb(1'b1, `STPG_OFS_CONTACT, 32'h0);
		stop_test();
	end
endmodule : stpg_top_tb
`default_nettype wire
